// >>> inc/settings_cmd_pkg.sv
// Constants and carrier types for the settings-write command decoder.
// Assumes one 20 MHz clock and a byte-serial report stream from the USB side.
package settings_cmd_pkg;
    // Report framing
    localparam int          REPORT_LEN      = 64;
    localparam logic [5:0]  LAST_INDEX      = 6'h3F;
    // Command and sub-codes
    localparam logic [7:0]  CMD_WRITE_NV    = 8'hB1;
    localparam logic [7:0]  SUB_CHIP        = 8'h00;
    localparam logic [7:0]  SUB_PINS        = 8'h01;
    localparam logic [7:0]  SUB_MFR_STR     = 8'h02;
    localparam logic [7:0]  SUB_PROD_STR    = 8'h03;
    localparam logic [7:0]  SUB_SER_STR     = 8'h04;
    // Response status codes
    localparam logic [7:0]  STATUS_OK       = 8'h00;
    localparam logic [7:0]  STATUS_UNSUPP   = 8'h01;
    // Byte indices
    localparam logic [5:0]  IDX_CMD         = 6'h00;
    localparam logic [5:0]  IDX_SUB         = 6'h01;
    localparam logic [5:0]  IDX_SEC         = 6'h02;
    localparam logic [5:0]  IDX_CLK         = 6'h03;
    localparam logic [5:0]  IDX_DAC         = 6'h04;
    localparam logic [5:0]  IDX_ADC         = 6'h05;
    localparam logic [5:0]  IDX_VID_LO      = 6'h06;
    localparam logic [5:0]  IDX_VID_HI      = 6'h07;
    // Field positions
    localparam int          POS_SER_EN      = 7;
    localparam int          POS_SEC_HI      = 1;
    localparam int          POS_CLK_HI      = 4;
    localparam int          POS_DACREF_HI   = 7;
    localparam int          POS_DACREF_LO   = 6;
    localparam int          POS_DAC_SRC     = 5;
    localparam int          POS_DACVAL_HI   = 4;
    localparam int          POS_NEG_EN      = 6;
    localparam int          POS_POS_EN      = 5;
    localparam int          POS_ADCREF_HI   = 4;
    localparam int          POS_ADCREF_LO   = 3;
    localparam int          POS_ADC_SRC     = 2;
    // Reset values of stored settings
    localparam logic [1:0]  RST_SECURITY    = 2'h0;
    localparam logic [4:0]  RST_CLK_DIV     = 5'h00;
    localparam logic [1:0]  RST_REF_LEVEL   = 2'h0;
    localparam logic [4:0]  RST_DAC_VALUE   = 5'h00;
    localparam logic [15:0] RST_VID         = 16'h0000;
    // Clock-output divider counter width
    localparam int          DIV_W           = 5;

    // Reference levels
    typedef enum logic [1:0] {
        REF_OFF  = 2'h0,
        REF_1V0  = 2'h1,
        REF_2V0  = 2'h2,
        REF_4V0  = 2'h3
    } ref_level_t;

    // Report byte stream
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } rx_byte_t;

    // Response report head
    typedef struct packed {
        logic       valid;
        logic [7:0] echo;
        logic [7:0] status;
    } resp_t;

    // Stored chip settings
    typedef struct packed {
        logic        serial_enum_en;
        logic [1:0]  security;
        logic [4:0]  clk_div;
        ref_level_t  dac_internal_reference;
        logic        dac_src_supply;
        logic [4:0]  dac_powerup;
        logic        int_neg_en;
        logic        int_pos_en;
        ref_level_t  adc_internal_reference;
        logic        adc_src_internal;
        logic [15:0] vendor_id;
    } chip_cfg_t;
endpackage : settings_cmd_pkg

// >>> verilog/edge_flag.sv
// Interrupt-detection edge catcher with enables for each polarity.
// Assumes an asynchronous pin; it is synchronised here before edge detection.
`timescale 1ns/1ns
module edge_flag (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Pin and enables
    input  wire logic pin,
    input  wire logic neg_en,
    input  wire logic pos_en,
    // Flag control
    input  wire logic clear,
    output logic      flag
);
    logic meta;    // First stage, read only by sync
    logic sync;    // Second stage
    logic prev;    // Last synced level

    // Two-stage synchroniser and history
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // Sticky flag; a new edge wins over a clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if ((neg_en && prev && !sync) || (pos_en && !prev && sync)) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end
endmodule : edge_flag

// >>> verilog/settings_write_decoder.sv
// Decoder for the nonvolatile settings-write command report.
// Assumes bytes arrive in order, byte 0 first, with last on byte 63.
`timescale 1ns/1ns
module settings_write_decoder
    import settings_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    // Report byte stream
    input  wire settings_cmd_pkg::rx_byte_t   rx,
    // Response head
    output settings_cmd_pkg::resp_t           resp,
    // Applied chip settings
    output settings_cmd_pkg::chip_cfg_t       cfg,
    output logic                              cfg_update,
    // Sub-command pulses for other stores
    output logic                              pin_store,
    output logic                              mfr_store,
    output logic                              prod_store,
    output logic                              ser_store,
    // Clock output
    input  wire logic                         clk_out_sel,
    output logic                              clk_out,
    // Interrupt detection
    input  wire logic                         int_pin,
    input  wire logic                         int_clear,
    output logic                              int_flag
);
    import settings_cmd_pkg::*;

    typedef enum {
        ST_CMD,
        ST_SUB,
        ST_PAYLOAD,
        ST_SKIP
    } parse_state_t;

    parse_state_t state;          // Parser state
    logic [5:0]   index;          // Byte position in report
    logic [7:0]   sub_code;       // Latched sub-code
    chip_cfg_t    shadow;         // Payload collected before commit
    logic         sub_known;      // Sub-code is one of the five
    logic         is_cmd;         // Byte 0 matches
    logic [DIV_W-1:0] div_cnt;    // Clock-output divider count
    logic         resp_cmd;       // This report carried the command code

    // Parsing is byte-serial, one byte per valid strobe.
    // Byte 0 and byte 1 steer the parser; later bytes are
    // routed by index into the shadow copy of the settings.
    // The shadow is only committed on the last byte, so a
    // report cut short by an early last commits the bytes
    // before that last one, and a foreign report never touches cfg.

    // Sub-code recognition
    always_comb begin
        sub_known = (rx.data == SUB_CHIP) || (rx.data == SUB_PINS) ||
                    (rx.data == SUB_MFR_STR) || (rx.data == SUB_PROD_STR) ||
                    (rx.data == SUB_SER_STR);
        is_cmd    = (rx.data == CMD_WRITE_NV);
    end

    // Byte position counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            index <= 6'h00;
        end else if (rx.valid) begin
            if (rx.last) begin
                index <= 6'h00;
            end else begin
                index <= index + 6'h01;
            end
        end
    end

    // Parser state machine
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= ST_CMD;
            sub_code <= SUB_CHIP;
        end else if (rx.valid) begin
            case (state)
                ST_CMD: begin
                    // Other commands are skipped whole
                    state <= is_cmd ? ST_SUB : ST_SKIP;
                end
                ST_SUB: begin
                    sub_code <= rx.data;
                    // Unknown sub-codes store nothing
                    state    <= sub_known ? ST_PAYLOAD : ST_SKIP;
                end
                ST_PAYLOAD: begin
                    state <= ST_PAYLOAD;
                end
                default: begin
                    state <= ST_SKIP;
                end
            endcase
            if (rx.last) begin
                state <= ST_CMD;
            end
        end
    end

    // Payload field capture for chip settings
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shadow <= '0;
        end else if (rx.valid && state == ST_PAYLOAD && sub_code == SUB_CHIP) begin
            // Fields decoded by position
            if (index == IDX_SEC) begin
                shadow.serial_enum_en <= rx.data[POS_SER_EN];
                shadow.security       <= rx.data[POS_SEC_HI:0];
            end else if (index == IDX_CLK) begin
                shadow.clk_div <= rx.data[POS_CLK_HI:0];
            end else if (index == IDX_DAC) begin
                shadow.dac_internal_reference <=
                    ref_level_t'(rx.data[POS_DACREF_HI:POS_DACREF_LO]);
                shadow.dac_src_supply <= rx.data[POS_DAC_SRC];
                shadow.dac_powerup    <= rx.data[POS_DACVAL_HI:0];
            end else if (index == IDX_ADC) begin
                shadow.int_neg_en <= rx.data[POS_NEG_EN];
                shadow.int_pos_en <= rx.data[POS_POS_EN];
                shadow.adc_internal_reference <=
                    ref_level_t'(rx.data[POS_ADCREF_HI:POS_ADCREF_LO]);
                shadow.adc_src_internal <= rx.data[POS_ADC_SRC];
            end else if (index == IDX_VID_LO) begin
                shadow.vendor_id[7:0] <= rx.data;
            end else if (index == IDX_VID_HI) begin
                shadow.vendor_id[15:8] <= rx.data;
            end
            // Unlisted bits and bytes never reach a field
        end
    end

    // Commit chip settings at end of a valid report
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg.serial_enum_en         <= 1'b0;
            cfg.security               <= RST_SECURITY;
            cfg.clk_div                <= RST_CLK_DIV;
            cfg.dac_internal_reference <= ref_level_t'(RST_REF_LEVEL);
            cfg.dac_src_supply         <= 1'b0;
            cfg.dac_powerup            <= RST_DAC_VALUE;
            cfg.int_neg_en             <= 1'b0;
            cfg.int_pos_en             <= 1'b0;
            cfg.adc_internal_reference <= ref_level_t'(RST_REF_LEVEL);
            cfg.adc_src_internal       <= 1'b0;
            cfg.vendor_id              <= RST_VID;
            cfg_update                 <= 1'b0;
        end else begin
            cfg_update <= 1'b0;
            if (rx.valid && rx.last && state == ST_PAYLOAD && sub_code == SUB_CHIP) begin
                cfg        <= shadow;
                cfg_update <= 1'b1;
            end
        end
    end

    // Store pulses for the other sub-commands
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_store  <= 1'b0;
            mfr_store  <= 1'b0;
            prod_store <= 1'b0;
            ser_store  <= 1'b0;
        end else begin
            pin_store  <= 1'b0;
            mfr_store  <= 1'b0;
            prod_store <= 1'b0;
            ser_store  <= 1'b0;
            if (rx.valid && rx.last && state == ST_PAYLOAD) begin
                // Dispatch by latched sub-code
                pin_store  <= (sub_code == SUB_PINS);
                mfr_store  <= (sub_code == SUB_MFR_STR);
                prod_store <= (sub_code == SUB_PROD_STR);
                ser_store  <= (sub_code == SUB_SER_STR);
            end
        end
    end

    // Response head after a recognised command report
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resp <= '0;
        end else begin
            resp.valid <= 1'b0;
            if (rx.valid && rx.last && (state == ST_PAYLOAD || state == ST_SKIP) &&
                index != IDX_CMD && resp_cmd) begin
                resp.valid  <= 1'b1;
                resp.echo   <= CMD_WRITE_NV;
                resp.status <= (state == ST_PAYLOAD) ? STATUS_OK
                                                     : STATUS_UNSUPP;
            end
        end
    end

    // Remembers that byte 0 matched, so skipped foreign reports stay silent.
    // Without it an unknown sub-code and a foreign command would look alike
    // in ST_SKIP, and the foreign one would wrongly be answered.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resp_cmd <= 1'b0;
        end else if (rx.valid && state == ST_CMD) begin
            resp_cmd <= is_cmd;
        end
    end

    // Clock-output divider: toggles every clk_div+1 cycles.
    // The output period is therefore 2*(clk_div+1) cycles.
    // Deselecting the pin parks the output low and restarts
    // the count, so the first half period after selection
    // is always a full one.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt <= '0;
            clk_out <= 1'b0;
        end else if (!clk_out_sel) begin
            div_cnt <= '0;
            clk_out <= 1'b0;
        end else if (div_cnt >= cfg.clk_div) begin
            div_cnt <= '0;
            clk_out <= ~clk_out;
        end else begin
            div_cnt <= div_cnt + 5'h01;
        end
    end

    // Interrupt-detection edge catcher.
    // Edge enables come from the committed settings, so a
    // new report changes the sensitivity only at commit.
    edge_flag u_edge_flag (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (int_pin),
        .neg_en  (cfg.int_neg_en),
        .pos_en  (cfg.int_pos_en),
        .clear   (int_clear),
        .flag    (int_flag)
    );
endmodule : settings_write_decoder

// >>> tb/settings_write_decoder_properties.sv
// Port checker for the settings-write decoder.
// Assumes it is bound onto the decoder and shares its single clock.
`timescale 1ns/1ns
module settings_write_decoder_properties
    import settings_cmd_pkg::*;
(
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       sys_rst,
    // Report in, results out
    input wire settings_cmd_pkg::rx_byte_t  rx,
    input wire settings_cmd_pkg::resp_t     resp,
    input wire settings_cmd_pkg::chip_cfg_t cfg,
    input wire logic                       cfg_update,
    input wire logic                       pin_store,
    input wire logic                       mfr_store,
    input wire logic                       prod_store,
    input wire logic                       ser_store,
    // Clock output and interrupt pin
    input wire logic                       clk_out_sel,
    input wire logic                       clk_out,
    input wire logic                       int_pin,
    input wire logic                       int_clear,
    input wire logic                       int_flag
);
    logic [5:0] idx;        // Byte position in report
    logic [7:0] hb [8];     // Header bytes seen
    logic       end_ok;     // Last byte of a write report
    logic [4:0] sel_vec;    // Expected update and store pulses

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Byte counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idx <= 6'h00;
        end else if (rx.valid) begin
            idx <= rx.last ? 6'h00 : idx + 6'h01;
        end
    end
    // Header capture
    always_ff @(posedge clk) begin
        if (rx.valid && idx < 6'h08) begin
            hb[idx[2:0]] <= rx.data;
        end
    end
    assign end_ok  = rx.valid && rx.last && hb[0] == CMD_WRITE_NV;
    assign sel_vec = {hb[1] == SUB_CHIP, hb[1] == SUB_PINS, hb[1] == SUB_MFR_STR,
                      hb[1] == SUB_PROD_STR, hb[1] == SUB_SER_STR};

    AST_RESP_ECHO: assert property (end_ok |=> resp.valid && resp.echo == CMD_WRITE_NV)
        else $error("response missing or echo wrong");
    AST_BAD_CMD_SILENT: assert property (rx.valid && rx.last && hb[0] != CMD_WRITE_NV
        |=> !resp.valid && !cfg_update) else $error("foreign command answered");
    AST_UNSUPPORTED: assert property (end_ok && hb[1] > SUB_SER_STR
        |=> resp.status == STATUS_UNSUPP) else $error("unsupported status missing");
    AST_OK_STATUS: assert property (end_ok && hb[1] <= SUB_SER_STR
        |=> resp.status == STATUS_OK) else $error("completion status wrong");
    AST_DISPATCH: assert property (end_ok |=> {cfg_update, pin_store, mfr_store, prod_store,
        ser_store} == $past(sel_vec)) else $error("sub-code dispatch wrong");
    AST_CFG_SECURITY: assert property (cfg_update |-> cfg.serial_enum_en == hb[2][7]
        && cfg.security == hb[2][1:0]) else $error("byte 2 fields wrong");
    AST_CFG_DAC: assert property (cfg_update |-> cfg.clk_div == hb[3][4:0]
        && cfg.dac_internal_reference == ref_level_t'(hb[4][7:6]) && cfg.dac_src_supply == hb[4][5]
        && cfg.dac_powerup == hb[4][4:0]) else $error("byte 3 or 4 fields wrong");
    AST_CFG_ADC: assert property (cfg_update |-> cfg.int_neg_en == hb[5][6]
        && cfg.int_pos_en == hb[5][5] && cfg.adc_internal_reference == ref_level_t'(hb[5][4:3])
        && cfg.adc_src_internal == hb[5][2] && cfg.vendor_id == {hb[7], hb[6]})
        else $error("byte 5 to 7 fields wrong");
    AST_CFG_HOLD: assert property (!cfg_update |-> $stable(cfg))
        else $error("settings changed without commit");
    AST_FLAG_STICKY: assert property (int_flag && !int_clear |=> int_flag)
        else $error("interrupt flag dropped");

    COV_CHIP: cover property (end_ok && hb[1] == SUB_CHIP);
    COV_UNSUPP: cover property (end_ok && hb[1] > SUB_SER_STR);
    COV_FLAG: cover property ($rose(int_flag));
endmodule : settings_write_decoder_properties

bind settings_write_decoder settings_write_decoder_properties u_props (.clk, .sys_rst, .rx,
    .resp, .cfg, .cfg_update, .pin_store, .mfr_store, .prod_store, .ser_store, .clk_out_sel,
    .clk_out, .int_pin, .int_clear, .int_flag);

// >>> tb/report_host.sv
// Host model that streams 64-byte command reports.
// Assumes the decoder takes one byte per clock while valid is high.
`timescale 1ns/1ns
module report_host
    import settings_cmd_pkg::*;
(
    // Clock
    input wire logic                  clk,
    // Report stream
    output settings_cmd_pkg::rx_byte_t rx
);
    initial rx = '0;

    // Sends header bytes 0..7, then filler up to byte 63
    task automatic send(input logic [63:0] hdr);
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            #1;
            rx.valid = 1'b1;
            rx.last  = (i == 63);
            rx.data  = (i < 8) ? hdr[8*i +: 8] : 8'(i);
        end
        @(posedge clk);
        #1;
        // Released data shows the inverse, never the last byte
        rx.valid = 1'b0;
        rx.last  = 1'b0;
        rx.data  = ~rx.data;
    endtask : send
endmodule : report_host

// >>> tb/tb.sv
// Self-checking bench for the settings-write decoder.
// Assumes the host model drives reports and outputs settle by 1 ns after the edge.
`timescale 1ns/1ns
module tb;
    import settings_cmd_pkg::*;
    logic      clk;
    logic      sys_rst;
    logic      clk_out_sel;
    logic      int_pin;
    logic      int_clear;
    rx_byte_t  rx;
    resp_t     resp;
    chip_cfg_t cfg;
    chip_cfg_t exp_cfg;
    logic      cfg_update, pin_store, mfr_store, prod_store, ser_store, clk_out, int_flag;
    int        mismatches = 0;
    int        samples_checked = 0;

    report_host u_host (.clk, .rx);
    settings_write_decoder u_settings_write_decoder (.clk, .sys_rst, .rx, .resp, .cfg,
        .cfg_update, .pin_store, .mfr_store, .prod_store, .ser_store, .clk_out_sel, .clk_out,
        .int_pin, .int_clear, .int_flag);

    // Compare one value
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Verdict and end of run
    task automatic summarize;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // Chip-settings write with pattern k, don't-care bits filled with a mix of 1s and 0s
    task automatic send_chip(input logic [1:0] k);
        logic [63:0] hdr;
        hdr = {6'h30, k, k, 6'h03, 1'b1, k[1], k[0], k, ~k[0], 2'b11, k, 1'b1, k,
               1'b1, k, 3'b101, k, 3'b011, k[0], 5'h15, k, SUB_CHIP, CMD_WRITE_NV};
        exp_cfg = '{k[0], k, {k, 3'b011}, ref_level_t'(k), 1'b1, {k, 1'b1, k}, k[1], k[0],
                    ref_level_t'(k), ~k[0], {6'h30, k, k, 6'h03}};
        u_host.send(hdr);
        chk("resp", {1'b1, CMD_WRITE_NV, STATUS_OK}, resp);
        chk("update", 1, cfg_update);
        chk("cfg", exp_cfg, cfg);
    endtask : send_chip

    // Other sub-codes, unknown ones and a foreign command
    task automatic t_other;
        logic [7:0] subs [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'hFF};
        for (int i = 0; i < 6; i++) begin
            u_host.send({48'h0, subs[i], CMD_WRITE_NV});
            chk("status", {1'b1, CMD_WRITE_NV, (subs[i] > SUB_SER_STR) ? STATUS_UNSUPP
                : STATUS_OK}, resp);
            chk("stores", {1'b0, subs[i] == 8'h01, subs[i] == 8'h02, subs[i] == 8'h03,
                subs[i] == 8'h04}, {cfg_update, pin_store, mfr_store, prod_store,
                ser_store});
            chk("cfg hold", exp_cfg, cfg);
        end
        u_host.send({48'h0, SUB_CHIP, 8'hB0});
        chk("silent", 0, {resp.valid, cfg_update});
    endtask : t_other

    // Move the interrupt pin, check the flag, then clear it
    task automatic pin_to(input logic v, input logic exp);
        int_pin = v;
        repeat (5) @(posedge clk);
        #1;
        chk("flag", exp, int_flag);
        int_clear = 1'b1;
        @(posedge clk);
        #1;
        int_clear = 1'b0;
    endtask : pin_to

    // Edge enables one at a time and together
    task automatic t_int;
        send_chip(2'h2);
        pin_to(1'b1, 1'b0);
        pin_to(1'b0, 1'b1);
        send_chip(2'h1);
        pin_to(1'b1, 1'b1);
        pin_to(1'b0, 1'b0);
        send_chip(2'h3);
        pin_to(1'b1, 1'b1);
        pin_to(1'b0, 1'b1);
    endtask : t_int

    // Clock output half period with divider 11
    task automatic t_clk;
        logic prev;
        int   n;
        send_chip(2'h1);
        clk_out_sel = 1'b1;
        for (int j = 0; j < 2; j++) begin
            prev = clk_out;
            n = 0;
            while (clk_out === prev && n < 40) begin
                @(posedge clk);
                #1;
                n++;
            end
        end
        chk("divide", 12, n);
    endtask : t_clk

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        clk_out_sel = 1'b0;
        int_pin = 1'b0;
        int_clear = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk("reset", 0, {cfg, resp, cfg_update});
        for (int k = 0; k < 4; k++) begin
            send_chip(2'(k));
        end
        t_other;
        t_int;
        t_clk;
        summarize;
    end

    // Watchdog
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        summarize;
    end
endmodule : tb
